/* src/hbi_pkg.sv */
// hbi_pkg: shared constants for the parallel host bus front end and its host-side driver.
// assumes both ends run on one 25 MHz clock, with a synchronous active-high reset.
package hbi_pkg;
	localparam int         HBI_AW   = 11;
	localparam int         HBI_DW   = 16;
	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [10:0] HBI_GL_CTRL1   = 11'h000;
	localparam logic [10:0] HBI_GL_SUMMARY = 11'h010;
	localparam logic [10:0] HBI_GL_UNMASK  = 11'h012;
	localparam logic [10:0] HBI_PORT_SUM   = 11'h050;
	localparam logic [10:0] HBI_FR_LATCHED = 11'h128;
	localparam logic [10:0] HBI_FR_IRQEN   = 11'h12c;
	// block spaces: global 0x000-0x03f, port 0x040-0x07f, framer 0x100-0x17f
	localparam logic [10:0] HBI_GL_LO   = 11'h000;
	localparam logic [10:0] HBI_GL_HI   = 11'h03f;
	localparam logic [10:0] HBI_PORT_LO = 11'h040;
	localparam logic [10:0] HBI_PORT_HI = 11'h07f;
	localparam logic [10:0] HBI_FR_LO   = 11'h100;
	localparam logic [10:0] HBI_FR_HI   = 11'h17f;
	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int HBI_CLR_METHOD_BIT = 0;
	localparam int HBI_IRQ_DRIVE_BIT  = 1;
	localparam int HBI_DP_RESET_BIT   = 2;
	localparam int HBI_GL_PORT_BIT    = 4;
	localparam int HBI_PORT_FR_BIT    = 0;
	localparam int HBI_FRAME_LOSS_BIT = 1;
	localparam logic [15:0] HBI_ZERO16   = 16'h0000;
	localparam logic [15:0] HBI_CTRL_RST = 16'h0004;
	// access completes one cycle more than this count after the strobe is seen
	localparam logic [1:0] HBI_ACC_CYC = 2'h2;
endpackage

/* src/hbi_bus_if.sv */
// hbi_bus_if: pins between the host processor and the device.
// assumes the testbench resolves data and interrupt wires from the enables.
`timescale 1ns/1ps
interface hbi_bus_if;
	logic [10:0] addr;
	logic [15:0] d_host;
	logic        d_host_oe_n;
	logic [15:0] d_dev;
	logic        d_dev_lo_oe_n;
	logic        d_dev_hi_oe_n;
	logic        rd_n;
	logic        wr_n;
	logic        data_strobe_n;
	logic        rw;
	logic        strobe_mode;
	logic        width16;
	logic        swap_select_pin;
	logic        rdy_n;
	logic        rdy_oe_n;
	logic        int_n;
	logic        int_oe_n;
	modport dev (input addr, d_host, rd_n, wr_n, data_strobe_n, rw, strobe_mode, width16,
		swap_select_pin, output d_dev, d_dev_lo_oe_n, d_dev_hi_oe_n, rdy_n, rdy_oe_n,
		int_n, int_oe_n);
	modport host (output addr, d_host, d_host_oe_n, rd_n, wr_n, data_strobe_n, rw,
		strobe_mode, width16, swap_select_pin, input d_dev, d_dev_lo_oe_n, d_dev_hi_oe_n,
		rdy_n, rdy_oe_n, int_n, int_oe_n);
endinterface

/* src/hbi_device.sv */
// hbi_device: parallel host bus slave, latched status clearing and interrupt tree.
// assumes bus pins are asynchronous to clk_in; the frame loss event comes from local logic.
`timescale 1ns/1ps
// Summary of operation
// - ready low once the access completes
// - no ready outside every block space
// - ready for reserved locations inside blocks
// - byte swap only in 16-bit width
// - swap low: bytes pass straight
// - swap high: bytes exchanged
// - host holds swap select static
// - mode 0: separate read, write strobes
// - mode 1: data strobe plus direction
// - clear-on-write clears bits written one
// - clear-on-read clears bits read set
// - event during clearing read still latches
// - host reads, then writes ones back
// - idle interrupt drives high or floats
// - interrupt floats after reset until active
// - global summary shows port origin
// - port summary shows framer origin
// - inactive framing mode raises no interrupt
// - data-path reset clears all latched bits
// - interrupt needs block enable and unmask
// - frame loss sets two summary bits
// - 8-bit width never drives upper lines
module hbi_device (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic ce_in,
	input  wire logic frame_loss_event_in,
	input  wire logic framer_mode_ds3_in,
	output logic      irq_active_out,
	hbi_bus_if.dev    bus
);
	import hbi_pkg::*;

	typedef enum logic [1:0] {HBI_IDLE, HBI_WAIT, HBI_DONE} hbi_st_t;

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic [2:0] rd_s_q, wr_s_q, ds_s_q;
	logic       rd_n_f_q, wr_n_f_q, ds_n_f_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_s_q   <= 3'h7;
			wr_s_q   <= 3'h7;
			ds_s_q   <= 3'h7;
			rd_n_f_q <= 1'b1;
			wr_n_f_q <= 1'b1;
			ds_n_f_q <= 1'b1;
		end else if (ce_in) begin
			rd_s_q <= {rd_s_q[1:0], bus.rd_n};
			wr_s_q <= {wr_s_q[1:0], bus.wr_n};
			ds_s_q <= {ds_s_q[1:0], bus.data_strobe_n};
			// a change counts once stages two and three agree
			if (rd_s_q[1] == rd_s_q[2]) rd_n_f_q <= rd_s_q[2];
			if (wr_s_q[1] == wr_s_q[2]) wr_n_f_q <= wr_s_q[2];
			if (ds_s_q[1] == ds_s_q[2]) ds_n_f_q <= ds_s_q[2];
		end
	end

	logic rd_req, wr_req, acc_req;
	always_comb begin
		rd_req = bus.strobe_mode ? (!ds_n_f_q && bus.rw)  : !rd_n_f_q;
		wr_req = bus.strobe_mode ? (!ds_n_f_q && !bus.rw) : !wr_n_f_q;
		acc_req = rd_req || wr_req;
	end

	// address is stable while a strobe is held, so it is read directly
	logic [10:0] word_addr;
	logic        in_space;
	always_comb begin
		word_addr = bus.width16 ? {bus.addr[10:1], 1'b0} : bus.addr;
		in_space  = (word_addr <= HBI_GL_HI) ||
			(word_addr >= HBI_PORT_LO && word_addr <= HBI_PORT_HI) ||
			(word_addr >= HBI_FR_LO && word_addr <= HBI_FR_HI);
	end

	// --------------------------------------------------------------
	// access sequencer
	// --------------------------------------------------------------
	hbi_st_t    st_q;
	logic [1:0] cnt_q;
	logic       rd_go, wr_go;
	always_comb begin
		rd_go = (st_q == HBI_WAIT) && cnt_q == HBI_ACC_CYC && rd_req && ce_in;
		wr_go = (st_q == HBI_WAIT) && cnt_q == HBI_ACC_CYC && wr_req && ce_in;
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_q  <= HBI_IDLE;
			cnt_q <= 2'h0;
		end else if (ce_in) begin
			case (st_q)
				HBI_IDLE: begin
					cnt_q <= 2'h0;
					if (acc_req && in_space) st_q <= HBI_WAIT;
				end
				HBI_WAIT: begin
					if (!acc_req) st_q <= HBI_IDLE;
					else if (cnt_q == HBI_ACC_CYC) st_q <= HBI_DONE;
					else cnt_q <= cnt_q + 2'h1;
				end
				HBI_DONE: begin
					if (!acc_req) st_q <= HBI_IDLE;
				end
				default: st_q <= HBI_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	logic [15:0] wdata, ctrl_q, unmask_q, fr_en_q, fr_lat_q, rd_word;
	always_comb begin
		if (bus.width16 && bus.swap_select_pin) wdata = {bus.d_host[7:0], bus.d_host[15:8]};
		else if (bus.width16) wdata = bus.d_host;
		else wdata = {8'h00, bus.d_host[7:0]};
	end
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_q   <= HBI_CTRL_RST;
			unmask_q <= HBI_ZERO16;
			fr_en_q  <= HBI_ZERO16;
		end else if (wr_go) begin
			case (word_addr)
				HBI_GL_CTRL1:  ctrl_q   <= wdata;
				HBI_GL_UNMASK: unmask_q <= wdata;
				HBI_FR_IRQEN:  fr_en_q  <= wdata;
				default: ;
			endcase
		end
	end

	logic dp_reset, fr_event, cor_hit, cow_hit;
	logic [15:0] fr_set;
	always_comb begin
		dp_reset = ctrl_q[HBI_DP_RESET_BIT];
		fr_event = frame_loss_event_in && framer_mode_ds3_in;
		fr_set   = HBI_ZERO16;
		fr_set[HBI_FRAME_LOSS_BIT] = fr_event;
		cor_hit  = rd_go && word_addr == HBI_FR_LATCHED && ctrl_q[HBI_CLR_METHOD_BIT];
		cow_hit  = wr_go && word_addr == HBI_FR_LATCHED && !ctrl_q[HBI_CLR_METHOD_BIT];
	end
	always_ff @(posedge clk_in) begin
		if (srst_in || (ce_in && dp_reset)) begin
			fr_lat_q <= HBI_ZERO16;
		end else if (ce_in) begin
			if (cor_hit) fr_lat_q <= fr_set;
			else if (cow_hit) fr_lat_q <= (fr_lat_q & ~wdata) | fr_set;
			else fr_lat_q <= fr_lat_q | fr_set;
		end
	end

	// --------------------------------------------------------------
	// interrupt tree
	// --------------------------------------------------------------
	logic [15:0] port_sum, gl_sum;
	always_comb begin
		port_sum = HBI_ZERO16;
		gl_sum   = HBI_ZERO16;
		port_sum[HBI_PORT_FR_BIT] = |(fr_lat_q & fr_en_q);
		gl_sum[HBI_GL_PORT_BIT] = |port_sum;
		case (word_addr)
			HBI_GL_CTRL1:   rd_word = ctrl_q;
			HBI_GL_SUMMARY: rd_word = gl_sum;
			HBI_GL_UNMASK:  rd_word = unmask_q;
			HBI_PORT_SUM:   rd_word = port_sum;
			HBI_FR_LATCHED: rd_word = fr_lat_q;
			HBI_FR_IRQEN:   rd_word = fr_en_q;
			default:        rd_word = HBI_ZERO16;
		endcase
	end

	logic [15:0] dout_q;
	logic        irq_q, irq_seen_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			dout_q     <= HBI_ZERO16;
			irq_q      <= 1'b0;
			irq_seen_q <= 1'b0;
		end else if (ce_in) begin
			if (rd_go) dout_q <= (bus.width16 && bus.swap_select_pin) ?
				{rd_word[7:0], rd_word[15:8]} : rd_word;
			irq_q <= |(gl_sum & unmask_q);
			if (|(gl_sum & unmask_q)) irq_seen_q <= 1'b1;
		end
	end

	logic rd_phase;
	always_comb begin
		rd_phase = (st_q == HBI_DONE) && rd_req;
		bus.rdy_n    = !(st_q == HBI_DONE);
		bus.rdy_oe_n = !(st_q == HBI_DONE);
		bus.d_dev    = dout_q;
		bus.d_dev_lo_oe_n = !rd_phase;
		bus.d_dev_hi_oe_n = !(rd_phase && bus.width16);
		bus.int_n    = !irq_q;
		bus.int_oe_n = !(irq_q || (irq_seen_q && ctrl_q[HBI_IRQ_DRIVE_BIT]));
		irq_active_out = irq_q;
	end
endmodule

/* src/hbi_host.sv */
// hbi_host: host processor side issuing single register reads and writes.
// assumes the device pins are asynchronous; ready is sampled through three flops.
`timescale 1ns/1ps
module hbi_host (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	input  wire logic        req_in,
	input  wire logic        write_in,
	input  wire logic [10:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        strobe_mode_in,
	input  wire logic        width16_in,
	input  wire logic        swap_in,
	output logic             busy_out,
	output logic             done_out,
	output logic [15:0]      rdata_out,
	output logic             irq_out,
	hbi_bus_if.host          bus
);
	import hbi_pkg::*;

	typedef enum logic [1:0] {HH_IDLE, HH_STROBE, HH_END} hh_st_t;

	logic [2:0] rdy_s_q, irq_s_q;
	logic       rdy_f_q, irq_f_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdy_s_q <= 3'h0;
			irq_s_q <= 3'h0;
			rdy_f_q <= 1'b0;
			irq_f_q <= 1'b0;
		end else if (ce_in) begin
			rdy_s_q <= {rdy_s_q[1:0], !bus.rdy_oe_n && !bus.rdy_n};
			irq_s_q <= {irq_s_q[1:0], !bus.int_oe_n && !bus.int_n};
			if (rdy_s_q[1] == rdy_s_q[2]) rdy_f_q <= rdy_s_q[2];
			if (irq_s_q[1] == irq_s_q[2]) irq_f_q <= irq_s_q[2];
		end
	end

	hh_st_t      st_q;
	logic        wr_q;
	logic [10:0] addr_q;
	logic [15:0] wd_q, rd_q;
	logic        done_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_q   <= HH_IDLE;
			wr_q   <= 1'b0;
			addr_q <= 11'h000;
			wd_q   <= HBI_ZERO16;
			rd_q   <= HBI_ZERO16;
			done_q <= 1'b0;
		end else if (ce_in) begin
			done_q <= 1'b0;
			case (st_q)
				HH_IDLE: if (req_in) begin
					wr_q   <= write_in;
					addr_q <= addr_in;
					wd_q   <= wdata_in;
					st_q   <= HH_STROBE;
				end
				HH_STROBE: if (rdy_f_q) begin
					if (!wr_q) rd_q <= bus.d_dev;
					st_q <= HH_END;
				end
				HH_END: if (!rdy_f_q) begin
					done_q <= 1'b1;
					st_q   <= HH_IDLE;
				end
				default: st_q <= HH_IDLE;
			endcase
		end
	end

	logic strobe;
	always_comb begin
		strobe = (st_q == HH_STROBE);
		bus.addr = addr_q;
		bus.d_host = wd_q;
		bus.d_host_oe_n = !(strobe && wr_q);
		bus.rd_n = !(strobe && !wr_q && !strobe_mode_in);
		bus.wr_n = !(strobe && wr_q && !strobe_mode_in);
		bus.data_strobe_n = !(strobe && strobe_mode_in);
		bus.rw = !wr_q;
		bus.strobe_mode = strobe_mode_in;
		bus.width16 = width16_in;
		bus.swap_select_pin = swap_in;
		busy_out  = (st_q != HH_IDLE);
		done_out  = done_q;
		rdata_out = rd_q;
		irq_out   = irq_f_q;
	end
endmodule

/* sim/hbi_checker.sv */
// hbi_checker: pin timing relations on the bus that joins host and device.
// assumes it watches the one interface between the two ends, on clk_in.
`timescale 1ns/1ps
module hbi_checker import hbi_pkg::*; (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic [10:0] addr,
	input wire logic        d_dev_lo_oe_n,
	input wire logic        d_dev_hi_oe_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        data_strobe_n,
	input wire logic        rw,
	input wire logic        strobe_mode,
	input wire logic        width16,
	input wire logic        rdy_n,
	input wire logic        rdy_oe_n,
	input wire logic        int_n,
	input wire logic        int_oe_n
);
	logic stb;
	logic wr;
	logic in_sp;
	// ------------------------------------------------------------
	// strobe decode, either strobe mode
	// ------------------------------------------------------------
	assign stb   = strobe_mode ? !data_strobe_n : (!rd_n || !wr_n);
	assign wr    = strobe_mode ? !rw : !wr_n;
	assign in_sp = addr <= HBI_PORT_HI || (addr >= HBI_FR_LO && addr <= HBI_FR_HI);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_wr_start; $rose(stb) && wr; endsequence
	sequence s_no_drive; d_dev_lo_oe_n [*6]; endsequence
	property p_rdy_pair; !rdy_oe_n |-> !rdy_n; endproperty
	a_rdy_pair: assert property (p_rdy_pair) else $error("ready enabled but high");
	// ready may outlive the strobe only by the release delay
	property p_rdy_cause; !rdy_oe_n |-> stb || $past(stb, 6); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready without strobe");
	property p_rdy_rel; $fell(stb) |-> ##[1:8] rdy_oe_n; endproperty
	a_rdy_rel: assert property (p_rdy_rel) else $error("ready not released");
	property p_unmapped; stb && !in_sp |-> rdy_oe_n; endproperty
	a_unmapped: assert property (p_unmapped) else $error("ready on unmapped address");
	property p_in_space; $rose(stb) && in_sp |-> ##[4:14] !rdy_oe_n; endproperty
	a_in_space: assert property (p_in_space) else $error("no ready in block space");
	property p_hi_8bit; !width16 |-> d_dev_hi_oe_n; endproperty
	a_hi_8bit: assert property (p_hi_8bit) else $error("upper lines driven in 8-bit");
	property p_both; width16 && !d_dev_lo_oe_n |-> !d_dev_hi_oe_n; endproperty
	a_both: assert property (p_both) else $error("upper half idle in 16-bit read");
	property p_wr_quiet; s_wr_start |-> s_no_drive; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("data driven in write");
	property p_int_float; $fell(srst_in) |-> int_oe_n [*8]; endproperty
	a_int_float: assert property (p_int_float) else $error("interrupt driven after reset");
	property p_int_idle; $fell(srst_in) |-> int_n; endproperty
	a_int_idle: assert property (p_int_idle) else $error("interrupt low after reset");
endmodule

/* sim/testbench.sv */
// testbench: host end and device end joined by the bus interface.
// assumes both ends share one 25 MHz clock; the bench drives the user sides.
`timescale 1ns/1ps
module testbench;
	import hbi_pkg::*;
	logic        clk_in;
	logic        srst_in;
	logic        req_in;
	logic        write_in;
	logic [10:0] addr_in;
	logic [15:0] wdata_in;
	logic        strobe_mode_in;
	logic        width16_in;
	logic        swap_in;
	logic        frame_loss_event_in;
	logic        framer_mode_ds3_in;
	logic        busy_out;
	logic        done_out;
	logic [15:0] rdata_out;
	logic        irq_out;
	logic        irq_active_out;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	int          miscompares;
	int          checks;
	hbi_bus_if bus ();
	hbi_device hbi_device_i (.clk_in, .srst_in, .ce_in(1'b1), .frame_loss_event_in,
		.framer_mode_ds3_in, .irq_active_out, .bus(bus.dev));
	hbi_host hbi_host_i (.clk_in, .srst_in, .ce_in(1'b1), .req_in, .write_in, .addr_in,
		.wdata_in, .strobe_mode_in, .width16_in, .swap_in, .busy_out, .done_out,
		.rdata_out, .irq_out, .bus(bus.host));
	hbi_checker hbi_checker_i (.clk_in, .srst_in, .addr(bus.addr),
		.d_dev_lo_oe_n(bus.d_dev_lo_oe_n), .d_dev_hi_oe_n(bus.d_dev_hi_oe_n),
		.rd_n(bus.rd_n), .wr_n(bus.wr_n), .data_strobe_n(bus.data_strobe_n), .rw(bus.rw),
		.strobe_mode(bus.strobe_mode), .width16(bus.width16), .rdy_n(bus.rdy_n),
		.rdy_oe_n(bus.rdy_oe_n), .int_n(bus.int_n), .int_oe_n(bus.int_oe_n));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one access; m masks the read compare, zero for writes
	task acc(input logic w, input logic [10:0] a, input logic [15:0] d, input logic [15:0] m);
		int n;
		@(posedge clk_in);
		#2;
		exp_q.push_back({m, d});
		{write_in, addr_in, wdata_in, req_in} = {w, a, d, 1'b1};
		strobe_mode_in = 1'($urandom % 2);
		@(posedge clk_in);
		#2;
		req_in = 1'b0;
		for (n = 0; n < 100 && done_out !== 1'b1; n++)
			@(posedge clk_in);
		if (n == 100) check("done", 16'h0000, 16'h0001);
		repeat (6) @(posedge clk_in);
		#2;
	endtask
	task rd(input logic [10:0] a, input logic [15:0] x);
		acc(1'b0, a, x, 16'hffff);
	endtask
	task wr(input logic [10:0] a, input logic [15:0] d);
		acc(1'b1, a, d, 16'h0000);
	endtask
	task pulse();
		@(posedge clk_in);
		#2;
		frame_loss_event_in = 1'b1;
		@(posedge clk_in);
		#2;
		frame_loss_event_in = 1'b0;
		repeat (8) @(posedge clk_in);
		#2;
	endtask
	always @(posedge clk_in) begin
		if (done_out === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[31:16] !== 16'h0000)
				check("rdata", rdata_out & e[31:16], e[15:0] & e[31:16]);
		end
	end
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// a hung access would otherwise stall the run
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		wrap_up();
	end
	initial begin
		{srst_in, width16_in, framer_mode_ds3_in} = 3'b111;
		{req_in, write_in, addr_in, wdata_in, strobe_mode_in, swap_in, frame_loss_event_in} = '0;
		miscompares = 0;
		checks = 0;
		void'($urandom(91));
		repeat (10) @(posedge clk_in);
		#2;
		srst_in = 1'b0;
		check("int_oe_n", 16'(bus.int_oe_n), 16'h0001);
		rd(HBI_GL_CTRL1, HBI_CTRL_RST);
		wr(HBI_GL_CTRL1, 16'h0000);
		wr(HBI_FR_IRQEN, 16'h0002);
		wr(HBI_GL_UNMASK, 16'h0010);
		rd(11'h02e, 16'h0000);
		pulse();
		check("irq", 16'(irq_out), 16'h0001);
		check("irq_active", 16'(irq_active_out), 16'h0001);
		check("int_n", 16'(bus.int_n), 16'h0000);
		rd(HBI_FR_LATCHED, 16'h0002);
		rd(HBI_PORT_SUM, 16'h0001);
		rd(HBI_GL_SUMMARY, 16'h0010);
		wr(HBI_FR_LATCHED, 16'hfffd);
		rd(HBI_FR_LATCHED, 16'h0002);
		wr(HBI_FR_LATCHED, 16'h0002);
		rd(HBI_FR_LATCHED, 16'h0000);
		rd(HBI_GL_SUMMARY, 16'h0000);
		check("int_oe_n", 16'(bus.int_oe_n), 16'h0001);
		wr(HBI_GL_CTRL1, 16'h0003);
		check("int_oe_n", 16'(bus.int_oe_n), 16'h0000);
		check("int_n", 16'(bus.int_n), 16'h0001);
		pulse();
		rd(HBI_FR_LATCHED, 16'h0002);
		rd(HBI_FR_LATCHED, 16'h0000);
		// event lands on the clearing read's completion edge, ten edges in
		fork
			rd(HBI_FR_LATCHED, 16'h0000);
			begin
				repeat (9) @(posedge clk_in);
				#2;
				frame_loss_event_in = 1'b1;
				@(posedge clk_in);
				#2;
				frame_loss_event_in = 1'b0;
			end
		join
		rd(HBI_FR_LATCHED, 16'h0002);
		framer_mode_ds3_in = 1'b0;
		pulse();
		check("irq", 16'(irq_out), 16'h0000);
		check("irq_active", 16'(irq_active_out), 16'h0000);
		rd(HBI_FR_LATCHED, 16'h0000);
		framer_mode_ds3_in = 1'b1;
		pulse();
		wr(HBI_GL_CTRL1, HBI_CTRL_RST);
		wr(HBI_GL_CTRL1, 16'h0001);
		rd(HBI_FR_LATCHED, 16'h0000);
		swap_in = 1'b1;
		rd(HBI_FR_IRQEN, 16'h0200);
		wr(HBI_FR_IRQEN, 16'h0100);
		swap_in = 1'b0;
		rd(HBI_FR_IRQEN, 16'h0001);
		width16_in = 1'b0;
		acc(1'b0, HBI_FR_IRQEN, 16'h0001, 16'h00ff);
		width16_in = 1'b1;
		{write_in, addr_in, req_in} = {1'b0, 11'h0c0, 1'b1};
		@(posedge clk_in);
		#2;
		req_in = 1'b0;
		repeat (40) @(posedge clk_in);
		#2;
		check("rdy_oe_n", 16'(bus.rdy_oe_n), 16'h0001);
		check("busy", 16'(busy_out), 16'h0001);
		srst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		#2;
		srst_in = 1'b0;
		check("int_oe_n", 16'(bus.int_oe_n), 16'h0001);
		// the host must recover from the hung access through reset alone
		rd(HBI_GL_CTRL1, HBI_CTRL_RST);
		wrap_up();
	end
endmodule
